// [psq_pkg.sv]
/*
 * Shared constants and types of the program sequencer.
 * Assumes one 200 MHz clock that stands for the oscillator.
 */
package psq_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int PSQ_PC_W    = 13;
	localparam int PSQ_BANK_W  = 4;
	localparam int PSQ_ADDR_W  = 18;
	localparam int PSQ_INSTR_W = 16;
	localparam int PSQ_PCL_W   = 8;
	localparam int PSQ_DATA_W  = 32;

	// ----------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------
	localparam logic [7:0] PSQ_PCL_IDX   = 8'h06;
	localparam logic [7:0] PSQ_BANK_IDX  = 8'h09;
	localparam logic [7:0] PSQ_STAT_IDX  = 8'h0a;
	localparam logic [7:0] PSQ_PCL_ADDR  = 8'(PSQ_PCL_IDX << 2);
	localparam logic [7:0] PSQ_BANK_ADDR = 8'(PSQ_BANK_IDX << 2);
	localparam logic [7:0] PSQ_STAT_ADDR = 8'(PSQ_STAT_IDX << 2);

	// ----------------------------------------
	// Reset values and vectors
	// ----------------------------------------
	localparam logic [12:0] PSQ_RESET_PC   = 13'h0000;
	localparam logic [3:0]  PSQ_RESET_BANK = 4'h0;
	localparam logic [12:0] PSQ_VEC_T0     = 13'h0008;
	localparam logic [12:0] PSQ_VEC_T1     = 13'h000c;
	localparam logic [12:0] PSQ_PC_ONE     = 13'h0001;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam logic [1:0] PSQ_PHASE_LAST = 2'h3;
	localparam logic [1:0] PSQ_PHASE_ONE  = 2'h1;
	localparam logic [1:0] PSQ_BANK_DELAY = 2'h2;
	localparam logic [1:0] PSQ_BANK_LAST  = 2'h1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		PSQ_OP_JUMP,
		PSQ_OP_CALL,
		PSQ_OP_RET,
		PSQ_OP_SKIP
	} psq_op_type;

	typedef enum logic [1:0] {
		PSQ_SEL_NONE,
		PSQ_SEL_PCL,
		PSQ_SEL_BANK,
		PSQ_SEL_STAT
	} psq_sel_type;

	typedef struct packed {
		logic        valid;
		psq_op_type  op;
		logic [12:0] target;
	} psq_cmd_type;

endpackage : psq_pkg

// [psq_phase_gen.sv]
/*
 * System clock enable (oscillator divided by two) and four phases.
 * Assumes hold_in is synchronous; it restarts the phase sequence.
 */
module psq_phase_gen
	import psq_pkg::*;
(
	input  wire logic       mclk_in,        // Oscillator clock
	input  wire logic       sys_rst_in,     // Async reset, high
	input  wire logic       hold_in,        // Core held in reset
	output logic            sys_en_out,     // System clock enable
	output logic [1:0]      phase_out,      // Current phase
	output logic            cycle_end_out   // Last phase of a cycle
);

	logic       div;
	logic       next_div;
	logic       next_sys_en;
	logic [1:0] next_phase;
	logic       next_cycle_end;

	// ----------------------------------------
	// Divider and phase counter
	// ----------------------------------------
	always_comb begin
		next_div       = ~div;
		next_sys_en    = div;
		next_phase     = sys_en_out ? 2'(phase_out + PSQ_PHASE_ONE) : phase_out;
		next_cycle_end = div && (next_phase == PSQ_PHASE_LAST);
		if (hold_in) begin
			next_div       = 1'b0;
			next_sys_en    = 1'b0;
			next_phase     = '0;
			next_cycle_end = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			div           <= 1'b0;
			sys_en_out    <= 1'b0;
			phase_out     <= '0;
			cycle_end_out <= 1'b0;
		end else begin
			div           <= next_div;
			sys_en_out    <= next_sys_en;
			phase_out     <= next_phase;
			cycle_end_out <= next_cycle_end;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_sys_half;
		@(posedge mclk_in) disable iff (sys_rst_in || hold_in)
		sys_en_out |=> !sys_en_out ##1 sys_en_out;
	endproperty
	a_sys_half: assert property (p_sys_half) else $error("enable not half rate");

endmodule : psq_phase_gen

// [psq_sequencer.sv]
/*
 * Program sequencer: instruction timing, fetch/execute overlap,
 * program counter, bank pointer and ROM word address.
 * Assumes the decoder presents its control command while the
 * instruction is in execute, and an APB master reaches the registers.
 */
//
// Summary of operation
// - System clock is oscillator divided by two, split into four phases.
// - One instruction cycle lasts four system clock periods.
// - Fetch of next instruction overlaps execution of current one.
// - Counter-changing instructions take two cycles via a dummy cycle.
// - Program counter is 13 bits, 8192 words per bank.
// - Counter increments by one after each fetch.
// - Jump, skip, PC_LOW_BYTE_REG write, call, return, reset, interrupt load counter.
// - True skip discards the prefetched instruction, runs a dummy cycle.
// - Low counter byte readable and writable at register 06H.
// - Writing the low byte jumps within the current 256-word page.
// - An 18-bit ROM word address reaches the 2M-bit ROM.
// - Program fetch address is built from bank pointer and counter.
// - External reset pin is active low and holds the core.
// - Fetch address equals bank times 2 to the 13 plus counter.
// - After reset execution starts at address 000H in bank 0.
// - Timer interrupts vector to 008H and 00CH within current bank.
// - Bank write takes effect after the following instruction completes.
module psq_sequencer
	import psq_pkg::*;
(
	input  wire logic              mclk_in,          // 200 MHz clock
	input  wire logic              sys_rst_in,       // Async reset, high
	input  wire logic              ext_reset_n_in,   // Reset pin, low
	input  wire logic [7:0]        paddr_in,         // APB address
	input  wire logic              psel_in,          // APB select
	input  wire logic              penable_in,       // APB enable
	input  wire logic              pwrite_in,        // APB direction
	input  wire logic [31:0]       pwdata_in,        // APB write data
	output logic [31:0]            prdata_out,       // APB read data
	output logic                   pready_out,       // APB ready
	output logic                   pslverr_out,      // APB error
	input  wire logic [15:0]       rom_data_in,      // ROM word
	input  wire psq_cmd_type       cmd_in,           // Decoder command
	input  wire logic              timer0_req_in,    // Timer 0 overflow
	input  wire logic              timer1_req_in,    // Timer 1 overflow
	input  wire logic              int_enable_in,    // Interrupts enabled
	input  wire logic              stack_full_in,    // Stack full
	output logic [17:0]            rom_word_address_out, // ROM address
	output logic [15:0]            instr_out,        // Instruction in execute
	output logic                   instr_valid_out,  // Not a dummy cycle
	output logic                   cycle_end_out,    // End of instruction cycle
	output logic [1:0]             phase_out,        // Phase clock index
	output logic                   sys_en_out,       // System clock enable
	output logic                   push_out,         // Push return address
	output logic [12:0]            push_addr_out,    // Address to push
	output logic                   int_ack_out,      // Interrupt taken
	output logic [12:0]            program_counter_bits_out, // Counter
	output logic [3:0]             bank_pointer_out  // Active bank
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic        hold;
	logic        apb_access;
	logic        apb_wr;
	psq_sel_type apb_sel;
	logic        int_take;
	logic        int_t0;
	logic        flush;

	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	logic [12:0] next_pc;
	logic [3:0]  next_bank;
	logic [17:0] next_rom_addr;
	logic [15:0] next_instr;
	logic        next_instr_valid;
	logic        next_push;
	logic [12:0] next_push_addr;
	logic        next_int_ack;
	logic        pcl_pend;
	logic        next_pcl_pend;
	logic [7:0]  pcl_val;
	logic [7:0]  next_pcl_val;
	logic [3:0]  bank_val;
	logic [3:0]  next_bank_val;
	logic [1:0]  bank_cnt;
	logic [1:0]  next_bank_cnt;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	function automatic psq_sel_type psq_decode(input logic [7:0] addr);
		unique case (addr)
			PSQ_PCL_ADDR:  psq_decode = PSQ_SEL_PCL;
			PSQ_BANK_ADDR: psq_decode = PSQ_SEL_BANK;
			PSQ_STAT_ADDR: psq_decode = PSQ_SEL_STAT;
			default:       psq_decode = PSQ_SEL_NONE;
		endcase
	endfunction : psq_decode

	function automatic logic [17:0] psq_fetch_addr(input logic [3:0] bank,
	                                               input logic [12:0] pc);
		psq_fetch_addr = {1'b0, bank, pc};
	endfunction : psq_fetch_addr

	assign hold       = ~ext_reset_n_in;
	assign apb_access = psel_in && penable_in;
	assign apb_wr     = apb_access && pready_out && pwrite_in;
	assign apb_sel    = psq_decode(paddr_in);

	// ----------------------------------------
	// Phase generator
	// ----------------------------------------
	psq_phase_gen u_phase (
		.mclk_in       (mclk_in),
		.sys_rst_in    (sys_rst_in),
		.hold_in       (hold),
		.sys_en_out    (sys_en_out),
		.phase_out     (phase_out),
		.cycle_end_out (cycle_end_out)
	);

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	always_comb begin
		next_pready  = apb_access && !pready_out;
		next_pslverr = 1'b0;
		next_prdata  = '0;
		if (next_pready) begin
			unique case (apb_sel)
				PSQ_SEL_PCL:  next_prdata = 32'(program_counter_bits_out[7:0]);
				PSQ_SEL_BANK: next_prdata = 32'(bank_pointer_out);
				PSQ_SEL_STAT: next_prdata = 32'({bank_pointer_out,
				                                  program_counter_bits_out});
				PSQ_SEL_NONE: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= '0;
		end else begin
			pready_out  <= next_pready;
			pslverr_out <= next_pslverr;
			prdata_out  <= next_prdata;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	assign int_t0   = timer0_req_in;
	assign int_take = cycle_end_out && !cmd_in.valid && !pcl_pend
	                  && int_enable_in && !stack_full_in
	                  && (timer0_req_in || timer1_req_in);

	always_comb begin
		next_pc          = program_counter_bits_out;
		next_bank        = bank_pointer_out;
		next_instr       = instr_out;
		next_instr_valid = instr_valid_out;
		next_push        = 1'b0;
		next_push_addr   = push_addr_out;
		next_int_ack     = 1'b0;
		next_pcl_pend    = pcl_pend;
		next_pcl_val     = pcl_val;
		next_bank_val    = bank_val;
		next_bank_cnt    = bank_cnt;
		flush            = 1'b0;

		if (cycle_end_out) begin
			if (cmd_in.valid) begin
				flush = 1'b1;
				unique case (cmd_in.op)
					PSQ_OP_JUMP: next_pc = cmd_in.target;
					PSQ_OP_CALL: begin
						next_pc        = cmd_in.target;
						next_push      = 1'b1;
						next_push_addr = program_counter_bits_out;
					end
					PSQ_OP_RET:  next_pc = cmd_in.target;
					PSQ_OP_SKIP: next_pc = program_counter_bits_out
					                       + PSQ_PC_ONE;
				endcase
			end else if (pcl_pend) begin
				flush         = 1'b1;
				next_pcl_pend = 1'b0;
				next_pc       = {program_counter_bits_out[12:8], pcl_val};
			end else if (int_take) begin
				flush          = 1'b1;
				next_push      = 1'b1;
				next_push_addr = program_counter_bits_out;
				next_int_ack   = 1'b1;
				next_pc        = int_t0 ? PSQ_VEC_T0 : PSQ_VEC_T1;
			end else begin
				next_pc = program_counter_bits_out + PSQ_PC_ONE;
			end
			// Fetched word moves to execute, or a dummy replaces it
			next_instr       = rom_data_in;
			next_instr_valid = !flush;
			if (bank_cnt != '0) begin
				next_bank_cnt = 2'(bank_cnt - PSQ_BANK_LAST);
				if (bank_cnt == PSQ_BANK_LAST) begin
					next_bank = bank_val;
				end
			end
		end

		// A register write in the same cycle wins over the consume
		if (apb_wr && apb_sel == PSQ_SEL_PCL) begin
			next_pcl_pend = 1'b1;
			next_pcl_val  = pwdata_in[7:0];
		end
		if (apb_wr && apb_sel == PSQ_SEL_BANK) begin
			next_bank_val = pwdata_in[3:0];
			next_bank_cnt = PSQ_BANK_DELAY;
		end

		if (hold) begin
			next_pc          = PSQ_RESET_PC;
			next_bank        = PSQ_RESET_BANK;
			next_instr       = '0;
			next_instr_valid = 1'b0;
			next_push        = 1'b0;
			next_int_ack     = 1'b0;
			next_pcl_pend    = 1'b0;
			next_bank_cnt    = '0;
		end
		next_rom_addr = psq_fetch_addr(next_bank, next_pc);
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			program_counter_bits_out <= PSQ_RESET_PC;
			bank_pointer_out         <= PSQ_RESET_BANK;
			rom_word_address_out     <= '0;
			instr_out                <= '0;
			instr_valid_out          <= 1'b0;
			push_out                 <= 1'b0;
			push_addr_out            <= '0;
			int_ack_out              <= 1'b0;
			pcl_pend                 <= 1'b0;
			pcl_val                  <= '0;
			bank_val                 <= '0;
			bank_cnt                 <= '0;
		end else begin
			program_counter_bits_out <= next_pc;
			bank_pointer_out         <= next_bank;
			rom_word_address_out     <= next_rom_addr;
			instr_out                <= next_instr;
			instr_valid_out          <= next_instr_valid;
			push_out                 <= next_push;
			push_addr_out            <= next_push_addr;
			int_ack_out              <= next_int_ack;
			pcl_pend                 <= next_pcl_pend;
			pcl_val                  <= next_pcl_val;
			bank_val                 <= next_bank_val;
			bank_cnt                 <= next_bank_cnt;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	property p_cycle_len;
		cycle_end_out && !hold |=> (!cycle_end_out || hold)[*7] ##1 (cycle_end_out || hold);
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("cycle not 8 clocks");

	property p_increment;
		cycle_end_out && !cmd_in.valid && !pcl_pend && !int_take && !hold
		|=> program_counter_bits_out == 13'($past(program_counter_bits_out) + PSQ_PC_ONE);
	endproperty
	a_increment: assert property (p_increment) else $error("pc not incremented");

	property p_jump;
		cycle_end_out && cmd_in.valid && cmd_in.op == PSQ_OP_JUMP && !hold
		|=> program_counter_bits_out == $past(cmd_in.target);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target not loaded");

	property p_dummy;
		cycle_end_out && cmd_in.valid && !hold |=> !instr_valid_out [*8];
	endproperty
	a_dummy: assert property (p_dummy) else $error("no dummy cycle");

	property p_address;
		rom_word_address_out == {1'b0, bank_pointer_out, program_counter_bits_out};
	endproperty
	a_address: assert property (p_address) else $error("rom address mismatch");

	property p_pcl_page;
		cycle_end_out && !cmd_in.valid && pcl_pend && !hold
		|=> program_counter_bits_out[12:8] == $past(program_counter_bits_out[12:8])
		    && program_counter_bits_out[7:0] == $past(pcl_val);
	endproperty
	a_pcl_page: assert property (p_pcl_page) else $error("pcl jump left page");

	property p_hold;
		hold |=> program_counter_bits_out == PSQ_RESET_PC
		         && bank_pointer_out == PSQ_RESET_BANK && !instr_valid_out;
	endproperty
	a_hold: assert property (p_hold) else $error("reset pin not obeyed");

	property p_vector;
		int_take && !hold |=> int_ack_out && push_out
		    && program_counter_bits_out == ($past(int_t0) ? PSQ_VEC_T0 : PSQ_VEC_T1)
		    && bank_pointer_out == $past(bank_pointer_out);
	endproperty
	a_vector: assert property (p_vector) else $error("bad interrupt vector");

	property p_bank_late;
		apb_wr && apb_sel == PSQ_SEL_BANK && !hold
		|=> bank_pointer_out == $past(bank_pointer_out);
	endproperty
	a_bank_late: assert property (p_bank_late) else $error("bank changed at once");

	c_skip: cover property (cycle_end_out && cmd_in.valid && cmd_in.op == PSQ_OP_SKIP);
	c_pcl:  cover property (cycle_end_out && pcl_pend && !cmd_in.valid);
	c_int:  cover property (int_take);
	c_bank: cover property (cycle_end_out && bank_cnt == PSQ_BANK_LAST);

endmodule : psq_sequencer

// [psq_rom_model.sv]
/*
 * Program ROM stand-in: each word is a fold of its own address.
 * Assumes the address holds steady while a fetch is pending.
 */
module psq_rom_model #(
	parameter int LAT = 2
) (
	input  wire logic        mclk_in,   // Clock
	input  wire logic [17:0] addr_in,   // Word address
	output logic      [15:0] data_out   // ROM word
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [17:0] last_addr = '0;
	int          age       = 0;
	logic [15:0] word;

	assign word = 16'(addr_in ^ (addr_in >> 5));
	// Until the word settles the lines carry its inverse, never a stale match
	assign data_out = (age >= LAT) ? word : ~word;

	always @(posedge mclk_in) begin
		last_addr <= addr_in;
		if (addr_in != last_addr) begin
			age <= 0;
		end else if (age < 100) begin
			age <= age + 1;
		end
	end
endmodule : psq_rom_model

// [psq_sequencer_tb.sv]
/*
 * Bench of the program sequencer: timing, counter, transfers, registers.
 * Assumes the ROM model answers well inside one instruction cycle.
 */
module psq_sequencer_tb import psq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [12:0] TGTS    [4] = '{13'h1fff, 13'h0a53, 13'h0123, 13'h0777};
	localparam logic [3:0]  IRQ_SET [5] = '{4'b1010, 4'b0110, 4'b1110, 4'b1000, 4'b1011};

	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        rstn    = 1'b1;
	logic [7:0]  paddr   = '0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] pwdata  = '0;
	psq_cmd_type cmd     = '0;
	logic        t0      = 1'b0;
	logic        t1      = 1'b0;
	logic        ien     = 1'b0;
	logic        sfull   = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, ivalid, cend, sen, push, ack;
	logic [15:0] rom_data, instr;
	logic [17:0] addr;
	logic [1:0]  phase;
	logic [12:0] push_a, pc;
	logic [3:0]  bank;
	int          mismatches  = 0;
	int          checks_done = 0;

	always #2.5 clk = ~clk;

	psq_sequencer psq_sequencer_inst (
		.mclk_in(clk), .sys_rst_in(rst), .ext_reset_n_in(rstn), .paddr_in(paddr),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.rom_data_in(rom_data), .cmd_in(cmd), .timer0_req_in(t0), .timer1_req_in(t1),
		.int_enable_in(ien), .stack_full_in(sfull), .rom_word_address_out(addr),
		.instr_out(instr), .instr_valid_out(ivalid), .cycle_end_out(cend),
		.phase_out(phase), .sys_en_out(sen), .push_out(push), .push_addr_out(push_a),
		.int_ack_out(ack), .program_counter_bits_out(pc), .bank_pointer_out(bank)
	);

	psq_rom_model #(.LAT(3)) psq_rom_model_inst (
		.mclk_in(clk), .addr_in(addr), .data_out(rom_data)
	);

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	function automatic logic [15:0] rw(input logic [17:0] a);
		return 16'(a ^ (a >> 5));
	endfunction : rw

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	// Stops at the falling edge just before a taking edge
	task automatic sync_ce;
		int n;
		n = 0;
		@(negedge clk);
		while (cend !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20)
			chk(cend, 1);
	endtask : sync_ce

	task automatic after_ce;
		sync_ce();
		@(negedge clk);
	endtask : after_ce

	task automatic issue(input psq_cmd_type c, input logic [3:0] q, output logic [12:0] p);
		sync_ce();
		repeat (8) @(posedge clk);
		cmd <= c;
		{t0, t1, ien, sfull} <= q;
		p = pc;
		@(posedge clk);
		cmd <= '0;
		{t0, t1, ien, sfull} <= 4'h0;
		@(negedge clk);
	endtask : issue

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Request stands until the edge that samples pready high
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			chk(pready, 1);
	endtask : apb

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_timing;
		int clks, ens;
		sync_ce();
		chk(phase, PSQ_PHASE_LAST);
		clks = 0;
		ens = 0;
		do begin
			@(negedge clk);
			clks++;
			ens += int'(sen === 1'b1);
		end while (cend !== 1'b1 && clks < 20);
		chk(clks, 8);
		chk(ens, 4);
	endtask : t_timing

	task automatic t_seq;
		logic [12:0] p;
		logic [17:0] a;
		after_ce();
		p = pc;
		a = addr;
		after_ce();
		chk(pc, 13'(p + 13'h1));
		chk(instr, rw(a));
		chk(ivalid, 1);
		chk(addr, {5'h0, p + 13'h1});
	endtask : t_seq

	task automatic t_ops;
		logic [12:0] p, e;
		for (int i = 0; i < 4; i++) begin
			issue('{1'b1, psq_op_type'(i), TGTS[i]}, 4'h0, p);
			e = (i == 3) ? p + 13'h1 : TGTS[i];
			chk(pc, e);
			chk(ivalid, 0);
			chk(push, i == 1);
			if (i == 1)
				chk(push_a, p);
			after_ce();
			chk(pc, 13'(e + 13'h1));
			chk(ivalid, 1);
			chk(instr, rw({5'h0, e}));
		end
	endtask : t_ops

	task automatic t_regs;
		logic [12:0] p;
		logic [31:0] rd;
		logic        err;
		issue('{1'b1, PSQ_OP_JUMP, 13'h1a40}, 4'h0, p);
		after_ce();
		apb(1'b1, PSQ_PCL_ADDR, 32'h0000_005c, rd, err);
		after_ce();
		chk(pc, 13'h1a5c);
		chk(ivalid, 0);
		chk(bank, 0);
		apb(1'b0, PSQ_PCL_ADDR, 32'h0, rd, err);
		chk(rd, 32'h0000_005c);
		after_ce();
		apb(1'b1, PSQ_BANK_ADDR, 32'h0000_0005, rd, err);
		after_ce();
		chk(bank, 0);
		p = pc;
		after_ce();
		chk(bank, 4'h5);
		chk(addr, {1'b0, 4'h5, p + 13'h1});
		apb(1'b0, PSQ_STAT_ADDR, 32'h0, rd, err);
		chk(rd[16:0], {4'h5, p + 13'h1});
		apb(1'b1, 8'h3c, 32'h1234_5678, rd, err);
		chk(err, 1);
		apb(1'b0, 8'h3c, 32'h0, rd, err);
		chk({err, rd}, {1'b1, 32'h0});
	endtask : t_regs

	task automatic t_irq;
		logic [12:0] p;
		logic [3:0]  q;
		logic        tk;
		for (int i = 0; i < 5; i++) begin
			q = IRQ_SET[i];
			tk = q[1] & ~q[0] & (q[3] | q[2]);
			issue('0, q, p);
			chk(ack, tk);
			chk(push, tk);
			chk(pc, tk ? (q[3] ? PSQ_VEC_T0 : PSQ_VEC_T1) : 13'(p + 13'h1));
			if (tk)
				chk(push_a, p);
			chk(addr[16:13], 4'h5);
			after_ce();
		end
	endtask : t_irq

	task automatic t_ext_reset;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		chk({bank, pc}, 17'h0);
		chk(addr, 0);
		chk(ivalid, 0);
		@(posedge clk);
		rstn <= 1'b1;
		after_ce();
		chk(pc, 13'h1);
		chk(instr, rw(18'h0));
	endtask : t_ext_reset

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({bank, pc}, 17'h0);
		t_timing();
		t_seq();
		t_ops();
		t_regs();
		t_irq();
		t_ext_reset();
		t_timing();
		tally_and_finish();
	end

	initial begin
		#20us;
		mismatches++;
		tally_and_finish();
	end
endmodule : psq_sequencer_tb
